//--- psl_sync.sv
/*
 * Shared constants for the strap, indicator and RMII pin block, plus a
 * two-flop level synchroniser.
 * Assumes each synchronised input is a slow level; the first flop feeds
 * only the second.
 */
`timescale 1ns/1ns
`default_nettype none

package psl_pkg;
	localparam int          CORE_CLK_MHZ      = 125;
	localparam int          SYNC_STAGES       = 2;
	localparam int          ADDR_W            = 5;
	localparam int          ADV_W             = 4;
	// Indicator mode field, bits [5:4] of the LED control register
	localparam logic [7:0]  LED_CTRL_OFFSET   = 8'h1f;
	localparam int          LED_MODE_LSB      = 4;
	localparam logic [1:0]  LED_MODE_ACT      = 2'h0;
	localparam logic [1:0]  LED_MODE_LINK     = 2'h1;
	// Basic control register bit positions loaded from the speed strap
	localparam int          CTRL_AN_EN_BIT    = 12;
	localparam int          CTRL_SPEED_BIT    = 13;
	localparam logic [7:0]  ADV_REG_OFFSET    = 8'h04;
	// Advertised abilities {100FD, 100HD, 10FD, 10HD}
	localparam logic [3:0]  ADV_ALL           = 4'hf;
	localparam logic [3:0]  ADV_10_ONLY       = 4'h3;
	localparam logic [1:0]  ADDR_UPPER_FIXED  = 2'h0;
	localparam logic [4:0]  ADDR_RESET        = 5'h00;
	localparam logic        AN_EN_RESET       = 1'h1;
	localparam logic        SPEED_RESET       = 1'h1;
	localparam logic        LED_OFF           = 1'h1;
	localparam logic        LED_ON            = 1'h0;
	localparam logic [1:0]  DIBIT_IDLE        = 2'h0;
endpackage : psl_pkg

module psl_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock
	input  wire logic             clk,
	// Asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule : psl_sync

`default_nettype wire

//--- psl_top.sv
/*
 * Strap capture at chip reset release, link indicator, and RMII dibit
 * paths between the line logic and the MAC.
 * Assumes LINE_* and LINK_UP/ACTIVITY come from on-chip logic on their
 * own clocks; RST_N_PIN and the strap inputs are raw pin levels.
 */
// What this block does
// RULE_01 - Link-only mode drives the lamp pin low when linked, else high.
// RULE_02 - Software must not select the reserved indicator modes 10 or 11.
// RULE_03 - Each valid reference clock period carries one receive dibit.
// RULE_04 - The MAC drives transmit dibits; one is taken per enabled period.
// RULE_05 - Address straps are latched at reset release and held until reset.
// RULE_06 - The low address strap sets address bits 1 and 0 to its level.
// RULE_07 - Address bits 4 and 3 are always zero.
// RULE_08 - Speed strap high: autoneg at 100 Mbps; low: 10 Mbps, no autoneg.
// RULE_09 - The speed strap loads control bits 12, 13 and the abilities.
// RULE_10 - Strap pins are inputs during reset and outputs afterwards.
// RULE_11 - The MAC must not drive the shared strap pins during reset.
// RULE_12 - LED control bits 5:4 pick the mode; its pin is the speed strap.
// RULE_13 - While chip reset is low, pins stay inputs and config at defaults.
`timescale 1ns/1ns
`default_nettype none

module psl_top
	import psl_pkg::*;
(
	// Core clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// Chip reset pin, active low
	input  wire logic        RST_N_PIN,
	// Strap pin levels seen during reset
	input  wire logic        ADDR_STRAP0_I,
	input  wire logic        ADDR_STRAP2_I,
	input  wire logic        LINK_INDICATOR_OUT_I,
	// Strap pin drivers, enable low while driving
	output var  logic        ADDR_STRAP0_OE_N,
	output var  logic        ADDR_STRAP2_OE_N,
	output var  logic        LINK_INDICATOR_OUT_O,
	output var  logic        LINK_INDICATOR_OUT_OE_N,
	// Captured configuration
	output var  logic [4:0]  STATION_ADDR_STRAP,
	output var  logic        AUTONEG_SPEED_STRAP,
	output var  logic        CTRL_AN_EN,
	output var  logic        CTRL_SPEED_100,
	output var  logic [3:0]  ADV_ABILITY,
	output var  logic        CONFIG_DONE,
	// Indicator control and status
	input  wire logic [1:0]  LED_MODE,
	input  wire logic        LINK_UP,
	input  wire logic        ACTIVITY,
	// RMII reference clock domain
	input  wire logic        REF_CLK,
	input  wire logic [1:0]  LINE_RXD,
	input  wire logic        LINE_RX_VALID,
	output var  logic [1:0]  RXD,
	output var  logic        CRS_DV,
	input  wire logic [1:0]  TXD,
	input  wire logic        TX_EN,
	output var  logic [1:0]  LINE_TXD,
	output var  logic        LINE_TX_EN
);
	////////////////////////////////////////////////////////////////////
	logic [3:0] pin_sync;
	logic       chip_run;
	logic       strap_a0;
	logic       strap_a2;
	logic       strap_spd;
	logic       in_reset;
	logic       done_reg;
	logic       link_live;

	psl_sync #(.WIDTH(4)) u_pin_sync (
		.clk (CORE_CLK),
		.d   ({RST_N_PIN, LINK_INDICATOR_OUT_I, ADDR_STRAP2_I,
		       ADDR_STRAP0_I}),
		.q   (pin_sync)
	);

	assign chip_run  = pin_sync[3];
	assign strap_spd = pin_sync[2];
	assign strap_a2  = pin_sync[1];
	assign strap_a0  = pin_sync[0];
	assign in_reset  = RST || !chip_run;

	////////////////////////////////////////////////////////////////////
	// Straps are synchronised as deep as the reset pin, so the sample
	// taken on the release cycle is the level held during reset.
	always_ff @(posedge CORE_CLK) begin
		if (in_reset) begin
			done_reg            <= 1'h0; // RULE_13
			STATION_ADDR_STRAP  <= ADDR_RESET;
			AUTONEG_SPEED_STRAP <= AN_EN_RESET;
			CTRL_AN_EN          <= AN_EN_RESET;
			CTRL_SPEED_100      <= SPEED_RESET;
			ADV_ABILITY         <= ADV_ALL;
		end else if (!done_reg) begin
			done_reg            <= 1'h1; // RULE_05
			STATION_ADDR_STRAP  <= {ADDR_UPPER_FIXED, strap_a2,
			                        strap_a0, strap_a0}; // RULE_06 RULE_07
			AUTONEG_SPEED_STRAP <= strap_spd; // RULE_12
			CTRL_AN_EN          <= strap_spd; // RULE_08 RULE_09
			CTRL_SPEED_100      <= strap_spd; // RULE_08 RULE_09
			ADV_ABILITY         <= strap_spd ? ADV_ALL : ADV_10_ONLY; // RULE_09
		end
	end

	assign CONFIG_DONE = done_reg;

	// Pins turn to outputs only after the capture cycle
	always_ff @(posedge CORE_CLK) begin
		if (in_reset) begin
			ADDR_STRAP0_OE_N        <= 1'h1; // RULE_10 RULE_13
			ADDR_STRAP2_OE_N        <= 1'h1; // RULE_10
			LINK_INDICATOR_OUT_OE_N <= 1'h1; // RULE_10
		end else begin
			ADDR_STRAP0_OE_N        <= !done_reg; // RULE_10
			ADDR_STRAP2_OE_N        <= !done_reg;
			LINK_INDICATOR_OUT_OE_N <= !done_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Activity mode toggles the lamp on every cycle that ACTIVITY is high while linked.
	// Reserved codes keep the lamp dark rather than guess a behaviour.
	always_ff @(posedge CORE_CLK) begin
		if (in_reset) begin
			LINK_INDICATOR_OUT_O <= LED_OFF;
		end else begin
			unique case (LED_MODE) // RULE_12
				LED_MODE_LINK: begin
					LINK_INDICATOR_OUT_O <= LINK_UP ? LED_ON : LED_OFF; // RULE_01
				end
				LED_MODE_ACT: begin
					if (!LINK_UP)
						LINK_INDICATOR_OUT_O <= LED_OFF;
					else if (ACTIVITY)
						LINK_INDICATOR_OUT_O <= !LINK_INDICATOR_OUT_O;
					else if (LINK_INDICATOR_OUT_O == LED_OFF &&
					         !ACTIVITY)
						LINK_INDICATOR_OUT_O <= LINK_INDICATOR_OUT_O;
				end
				default: begin
					LINK_INDICATOR_OUT_O <= LED_OFF; // RULE_02
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link side runs only once configuration is done; the level crosses
	// by two flops, so the MAC pins stay idle through chip reset.
	psl_sync #(.WIDTH(1)) u_live_sync (
		.clk (REF_CLK),
		.d   (done_reg),
		.q   (link_live)
	);

	always_ff @(posedge REF_CLK) begin
		if (!link_live) begin
			CRS_DV <= 1'b0;
			RXD    <= DIBIT_IDLE;
		end else begin
			CRS_DV <= LINE_RX_VALID; // RULE_03
			RXD    <= LINE_RX_VALID ? LINE_RXD : DIBIT_IDLE; // RULE_03
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!link_live) begin
			LINE_TX_EN <= 1'b0;
			LINE_TXD   <= DIBIT_IDLE;
		end else begin
			LINE_TX_EN <= TX_EN; // RULE_04
			LINE_TXD   <= TX_EN ? TXD : DIBIT_IDLE; // RULE_04
		end
	end

	////////////////////////////////////////////////////////////////////
	// The lamp seen now was set one edge ago, so reset is judged there
	led_link_only_a: assert property ( // RULE_01
		@(posedge CORE_CLK) disable iff (RST)
		(chip_run && $past(chip_run) && !$past(RST) &&
		 $past(LED_MODE) == LED_MODE_LINK)
		|-> LINK_INDICATOR_OUT_O == ($past(LINK_UP) ? LED_ON : LED_OFF))
		else $error("indicator does not follow link");

	led_reserved_a: assert property ( // RULE_02
		@(posedge CORE_CLK) disable iff (RST)
		($past(LED_MODE) > LED_MODE_LINK)
		|-> LINK_INDICATOR_OUT_O == LED_OFF)
		else $error("reserved mode lit the lamp");

	addr_capture_a: assert property ( // RULE_05
		@(posedge CORE_CLK) disable iff (RST)
		(!in_reset && !done_reg) |=>
		STATION_ADDR_STRAP == {ADDR_UPPER_FIXED, $past(strap_a2),
		                      $past(strap_a0), $past(strap_a0)})
		else $error("address not captured at release");

	addr_hold_a: assert property ( // RULE_05
		@(posedge CORE_CLK) disable iff (RST)
		(done_reg && !in_reset) |=> $stable(STATION_ADDR_STRAP))
		else $error("address changed after capture");

	addr_pair_a: assert property ( // RULE_06
		@(posedge CORE_CLK) disable iff (RST)
		STATION_ADDR_STRAP[1] == STATION_ADDR_STRAP[0])
		else $error("address bits 1 and 0 differ");

	addr_upper_a: assert property ( // RULE_07
		@(posedge CORE_CLK) disable iff (RST)
		STATION_ADDR_STRAP[4:3] == ADDR_UPPER_FIXED)
		else $error("address bits 4 and 3 not zero");

	speed_load_a: assert property ( // RULE_09
		@(posedge CORE_CLK) disable iff (RST)
		CTRL_AN_EN == CTRL_SPEED_100 &&
		ADV_ABILITY == (CTRL_SPEED_100 ? ADV_ALL : ADV_10_ONLY))
		else $error("speed strap outputs disagree");

	pins_input_a: assert property ( // RULE_10
		@(posedge CORE_CLK) disable iff (RST)
		!done_reg |=> ADDR_STRAP0_OE_N && ADDR_STRAP2_OE_N &&
		LINK_INDICATOR_OUT_OE_N)
		else $error("strap pin driven before capture");

	reset_default_a: assert property ( // RULE_13
		@(posedge CORE_CLK) disable iff (RST)
		!chip_run |=> STATION_ADDR_STRAP == ADDR_RESET && !done_reg)
		else $error("config not at default in chip reset");

	// Sampled link_live guards the edge on which the link side wakes
	rx_pass_a: assert property ( // RULE_03
		@(posedge REF_CLK) disable iff (!link_live)
		(link_live && LINE_RX_VALID)
		|=> CRS_DV && RXD == $past(LINE_RXD))
		else $error("receive dibit lost");

	tx_pass_a: assert property ( // RULE_04
		@(posedge REF_CLK) disable iff (!link_live)
		(link_live && TX_EN)
		|=> LINE_TX_EN && LINE_TXD == $past(TXD))
		else $error("transmit dibit lost");

	release_c: cover property (@(posedge CORE_CLK) disable iff (RST)
		!done_reg ##1 done_reg);
	slow_strap_c: cover property (@(posedge CORE_CLK) disable iff (RST)
		done_reg && !CTRL_SPEED_100);
	link_lamp_c: cover property (@(posedge CORE_CLK) disable iff (RST)
		done_reg && LINK_INDICATOR_OUT_O == LED_ON);
	rx_frame_c: cover property (@(posedge REF_CLK) disable iff (!link_live)
		CRS_DV [*4]);
endmodule : psl_top

`default_nettype wire

//--- psl_mac_model.sv
/* MAC side of the RMII transmit path.
   Assumes the bench raises go only after configuration is done. */
`timescale 1ns/1ns
`default_nettype none
module psl_mac_model (
	// Link clock and request
	input  wire logic       ref_clk,
	input  wire logic       go,
	// Transmit dibits
	output var  logic [1:0] txd,
	output var  logic       tx_en
);
	logic [1:0] cnt_reg;
	initial begin
		txd = 2'h0;
		tx_en = 1'h0;
		cnt_reg = 2'h0;
	end
	// No port reaches the shared strap pins, so nothing stray in reset
	always @(posedge ref_clk) begin
		tx_en <= go && cnt_reg != 2'h3;
		// Idle data is inverted so stale values never look valid
		txd <= go ? cnt_reg : ~txd;
		cnt_reg <= cnt_reg + 2'h1;
	end
endmodule : psl_mac_model
`default_nettype wire

//--- psl_top_test.sv
/* Self-checking bench for psl_top: straps, indicator, RMII paths.
   Assumes strap pins read the pull level until the device drives them. */
`timescale 1ns/1ns
`default_nettype none
module psl_top_test;
	import psl_pkg::*;
	logic core_clk = 0, ref_clk = 0, rst = 1, rst_n = 0, go = 0;
	logic s0 = 0, s2 = 0, spd = 1, link_up = 0, act = 0, rxv = 0;
	logic [1:0] led_mode = LED_MODE_LINK, line_rxd = 0;
	wire logic oe0_n, oe2_n, led_o, led_oe_n, done, an_sp, an_en, sp100;
	wire logic crs_dv, tx_en, line_tx_en;
	wire logic [1:0] rxd, txd, line_txd;
	wire logic [4:0] addr;
	wire logic [3:0] adv;
	int n_mismatch = 0;
	int checks_done = 0;
	always #4 core_clk = ~core_clk;
	always #3 ref_clk = ~ref_clk;
	psl_top u_psl_top (.CORE_CLK(core_clk), .RST(rst), .RST_N_PIN(rst_n),
		.ADDR_STRAP0_I(oe0_n ? s0 : crs_dv),
		.ADDR_STRAP2_I(oe2_n ? s2 : ref_clk),
		.LINK_INDICATOR_OUT_I(led_oe_n ? spd : led_o),
		.ADDR_STRAP0_OE_N(oe0_n), .ADDR_STRAP2_OE_N(oe2_n),
		.LINK_INDICATOR_OUT_O(led_o), .LINK_INDICATOR_OUT_OE_N(led_oe_n),
		.STATION_ADDR_STRAP(addr), .AUTONEG_SPEED_STRAP(an_sp),
		.CTRL_AN_EN(an_en), .CTRL_SPEED_100(sp100), .ADV_ABILITY(adv),
		.CONFIG_DONE(done), .LED_MODE(led_mode), .LINK_UP(link_up),
		.ACTIVITY(act), .REF_CLK(ref_clk), .LINE_RXD(line_rxd),
		.LINE_RX_VALID(rxv), .RXD(rxd), .CRS_DV(crs_dv), .TXD(txd),
		.TX_EN(tx_en), .LINE_TXD(line_txd), .LINE_TX_EN(line_tx_en));
	psl_mac_model u_psl_mac_model (.ref_clk(ref_clk), .go(go),
		.txd(txd), .tx_en(tx_en));
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	// Straps are set opposite first, so only the level at release counts
	task automatic strap_test;
		for (int k = 0; k < 8; k++) begin
			rst_n = 0;
			{s0, s2, spd} = ~k[2:0];
			cyc(4);
			chk("oe", {oe0_n, oe2_n, led_oe_n}, 8'h7);
			chk("dflt", {done, addr, an_en, sp100}, 8'h3);
			{s0, s2, spd} = k[2:0];
			cyc(4);
			rst_n = 1;
			for (int i = 0; i < 10 && done !== 1'b1; i++) cyc(1);
			cyc(3);
			chk("addr", addr, {3'h0, s2, s0, s0});
			chk("ctl", {an_sp, an_en, sp100}, {3{spd}});
			chk("adv", adv, spd ? ADV_ALL : ADV_10_ONLY);
			chk("oe_n", {oe0_n, oe2_n, led_oe_n}, 8'h0);
		end
		$display("strap test done");
	endtask : strap_test
	task automatic led_test;
		led_mode = LED_MODE_LINK;
		link_up = 1;
		cyc(3);
		chk("led on", led_o, LED_ON);
		link_up = 0;
		cyc(3);
		chk("led off", led_o, LED_OFF);
		link_up = 1;
		for (int m = 2; m < 4; m++) begin
			led_mode = m[1:0];
			cyc(3);
			chk("led rsv", led_o, LED_OFF);
		end
		led_mode = LED_MODE_ACT;
		cyc(3);
		chk("led idle", led_o, LED_OFF);
		act = 1;
		cyc(1);
		act = 0;
		cyc(3);
		chk("led act", led_o, LED_ON);
		link_up = 0;
		cyc(3);
		chk("led nolink", led_o, LED_OFF);
		$display("led test done");
	endtask : led_test
	// Back-to-back words with gaps in both directions
	task automatic rmii_test;
		logic pv, pe;
		logic [1:0] pd, pt;
		go = 1;
		repeat (4) @(negedge ref_clk);
		pe = tx_en;
		pt = txd;
		pv = 0;
		pd = 0;
		for (int i = 0; i < 16; i++) begin
			@(negedge ref_clk);
			chk("crs_dv", crs_dv, pv);
			chk("rxd", rxd, pv ? pd : DIBIT_IDLE);
			chk("tx_en", line_tx_en, pe);
			chk("txd", line_txd, pe ? pt : DIBIT_IDLE);
			pe = tx_en;
			pt = txd;
			rxv = i % 4 != 3;
			line_rxd = i[1:0] ^ 2'h2;
			pv = rxv;
			pd = line_rxd;
		end
		go = 0;
		$display("rmii test done");
	endtask : rmii_test
	initial begin
		cyc(16);
		rst = 0;
		strap_test();
		led_test();
		rmii_test();
		end_sim();
	end
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule : psl_top_test
`default_nettype wire
